// File: spi_master_slave_port_bench.sv
// Self-checking bench for the serial master/slave port.
`timescale 1ns/100ps
module spi_master_slave_port_bench;
   import spms_pkg::*;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic [ADDR_W-1:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic pready, pslverr, irq, sclk_o, sclk_oe, mosi_o, mosi_oe, miso_o, miso_oe;
   logic sel_n = 1'b1, ld = 1'b0, m_miso, err, sk = 1'b0, bs = 1'b0, bm = 1'b0;
   logic [7:0] ctl = 8'h00, s_tx = 8'h00, s_rx, v;
   int n_mismatch = 0, samples_checked = 0, cyc = 0, ed = 0, t0 = 0, t1 = 0;
   wire sclk_w = sclk_oe ? sclk_o : bs;
   wire mosi_w = mosi_oe ? mosi_o : (sel_n ? ~sclk_w : bm);
   wire miso_w = miso_oe ? miso_o : m_miso;
   always #25 pclk = ~pclk;
   spms_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr), .irq(irq), .sclk_i(sclk_w), .sclk_o(sclk_o), .sclk_oe(sclk_oe),
      .mosi_i(mosi_w), .mosi_o(mosi_o), .mosi_oe(mosi_oe), .miso_i(miso_w), .miso_o(miso_o),
      .miso_oe(miso_oe), .select_n_i(sel_n));
   spms_slave_model u_far (.sclk(sclk_w), .mosi(mosi_w), .pol(ctl[BIT_POL]),
      .pha(ctl[BIT_PHA]), .ord(ctl[BIT_ORD]), .load(ld), .tx(s_tx), .miso(m_miso), .rx(s_rx));
   // ------------------------------------------------------------
   // Serial clock edge counter and run limit
   // ------------------------------------------------------------
   always @(negedge pclk) begin
      cyc++;
      if (sclk_o !== sk) begin
         if (ed == 0) t0 = cyc;
         t1 = cyc;
         ed++;
      end
      sk = sclk_o;
      if (cyc == 30000) begin
         n_mismatch++;
         summarize();
      end
   end
   // ------------------------------------------------------------
   // Shared tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= {2'h0, idx, ADDR_LSB_ZERO};
      pwdata <= {24'h0, wd};
      @(posedge pclk);
      penable <= 1'b1;
      do @(posedge pclk); while (pready !== 1'b1);
      v = prdata[7:0];
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic summarize;
      $display("checks=%0d mismatches=%0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0) $display("TB: PASS");
      else $display("TB: FAIL");
      $finish;
   endtask
   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic regs;
      apb(0, IDX_CONTROL, 0);
      chk(v, CONTROL_RESET);
      apb(1, IDX_CONTROL, 8'hA7);
      apb(0, IDX_CONTROL, 0);
      chk(v, 8'hA7);
      apb(1, 8'hD0, 8'hFF);
      chk(err, 1'b1);
      apb(0, 8'hD0, 0);
      chk(v, 8'h00);
      apb(1, IDX_CONTROL, 8'h00);
      repeat (6) @(posedge pclk);
      chk({sclk_oe, mosi_oe, miso_oe}, 3'b000);
      $display("test regs done");
   endtask
   task automatic xfer(input logic [7:0] c, input logic [7:0] md, input logic [7:0] sd,
         input logic rdchk, input logic col);
      ctl = c;
      s_tx = sd;
      apb(1, IDX_CONTROL, c);
      // Load the far side only once the clock pin has settled to the new polarity.
      repeat (4) @(posedge pclk);
      ld <= ~ld;
      chk({sclk_oe, mosi_oe, miso_oe}, 3'b110);
      ed = 0;
      apb(1, IDX_DATA, md);
      if (col) apb(1, IDX_DATA, 8'h3C);
      for (int k = 0; k < 2000 && irq !== 1'b1; k++) @(posedge pclk);
      repeat (2) @(posedge pclk);
      chk(ed, 16);
      chk(t1 - t0, 15 * (2 << c[1:0]));
      chk(sclk_o, c[BIT_POL]);
      chk(s_rx, md);
      apb(0, IDX_STATUS, 0);
      chk(v, col ? 8'hC0 : 8'h80);
      chk(irq, 1'b1);
      apb(0, IDX_DATA, 0);
      if (rdchk) chk(v, sd);
      if (col) begin
         apb(1, IDX_STATUS, 8'h00);
         apb(0, IDX_STATUS, 0);
         chk(v, 8'hC0);
         apb(1, IDX_STATUS, 8'h40);
         apb(0, IDX_STATUS, 0);
         chk(v, 8'h80);
      end
      apb(1, IDX_STATUS, 8'h80);
      apb(0, IDX_STATUS, 0);
      chk(v, 8'h00);
      $display("test xfer ctl=%h done", c);
   endtask
   task automatic demote;
      ctl = 8'h50;
      apb(1, IDX_CONTROL, 8'h50);
      repeat (8) @(posedge pclk);
      apb(1, IDX_STATUS, 8'hC0);
      chk({sclk_oe, mosi_oe, miso_oe}, 3'b110);
      sel_n <= 1'b0;
      repeat (12) @(posedge pclk);
      chk({sclk_oe, mosi_oe, miso_oe}, 3'b001);
      apb(0, IDX_CONTROL, 0);
      chk(v, 8'h40);
      apb(0, IDX_STATUS, 0);
      chk(v, 8'h80);
      sel_n <= 1'b1;
      repeat (12) @(posedge pclk);
      chk(miso_oe, 1'b0);
      apb(0, IDX_CONTROL, 0);
      chk(v, 8'h40);
      apb(1, IDX_CONTROL, 8'h00);
      repeat (6) @(posedge pclk);
      chk({sclk_oe, mosi_oe, miso_oe}, 3'b000);
      $display("test demote done");
   endtask
   // The bench acts as a phase-0 master and frames the byte with select.
   task automatic slv(input logic [7:0] bd, input logic [7:0] sd);
      logic [7:0] got;
      got = 8'h00;
      ctl = 8'h40;
      apb(1, IDX_CONTROL, 8'h40);
      apb(1, IDX_DATA, sd);
      sel_n <= 1'b0;
      repeat (8) @(posedge pclk);
      for (int b = 0; b < 8; b++) begin
         bm <= bd[7 - b];
         repeat (16) @(posedge pclk);
         got = {got[6:0], miso_w};
         bs <= 1'b1;
         repeat (16) @(posedge pclk);
         bs <= 1'b0;
      end
      repeat (8) @(posedge pclk);
      chk(got, sd);
      apb(0, IDX_DATA, 0);
      chk(v, bd);
      apb(1, IDX_DATA, 8'h55);
      apb(0, IDX_STATUS, 0);
      chk(v, 8'hC0);
      apb(0, IDX_DATA, 0);
      chk(v, bd);
      apb(1, IDX_STATUS, 8'hC0);
      sel_n <= 1'b1;
      repeat (8) @(posedge pclk);
      apb(1, IDX_CONTROL, 8'h00);
      $display("test slv done");
   endtask
   initial begin
      logic [2:0] kk;
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
      regs();
      for (int k = 0; k < 8; k++) begin
         kk = k[2:0];
         xfer({2'b11, kk[2], 1'b1, kk[1], kk[0], 2'h3}, 8'h1D + 8'(k), 8'hB2 - 8'(k), 1, 0);
      end
      for (int r = 0; r < 3; r++) xfer({6'h34, r[1:0]}, 8'h81, 8'h00, 0, 0);
      xfer(8'hD7, 8'hA5, 8'h6E, 1, 1);
      demote();
      slv(8'hC6, 8'h39);
      summarize();
   end
endmodule // spi_master_slave_port_bench

// File: spms_pkg.sv
// Package of constants and carrier types for the serial master/slave port.
package spms_pkg;

   // ------------------------------------------------------------
   // Register map
   // ------------------------------------------------------------
   // Printed offsets are not all multiples of four, so each is an index.
   localparam logic [7:0] IDX_STATUS = 8'hCD;
   localparam logic [7:0] IDX_CONTROL = 8'hCE;
   localparam logic [7:0] IDX_DATA = 8'hCF;
   localparam int ADDR_W = 12;
   localparam logic [1:0] ADDR_LSB_ZERO = 2'h0;

   // ------------------------------------------------------------
   // Field positions
   // ------------------------------------------------------------
   localparam int BIT_TCF = 7;
   localparam int BIT_WCF = 6;
   localparam int BIT_SIG = 7;
   localparam int BIT_EN = 6;
   localparam int BIT_ORD = 5;
   localparam int BIT_MST = 4;
   localparam int BIT_POL = 3;
   localparam int BIT_PHA = 2;
   localparam logic [7:0] CONTROL_RESET = 8'h00;
   localparam logic [7:0] DATA_RESET = 8'h00;

   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   // Half-period of the serial clock in system clocks per rate code: 2, 4, 8, 16.
   localparam logic [3:0] HALF_BASE = 4'h2;
   localparam logic [3:0] BITS_PER_BYTE = 4'h8;
   localparam logic [4:0] EDGES_PER_BYTE = 5'h10;

   typedef struct packed {
      logic sig;
      logic en;
      logic ord;
      logic mst;
      logic pol;
      logic pha;
      logic [1:0] rate;
   } spms_ctrl_type;

   typedef struct packed {
      logic o;
      logic oe;
   } spms_drive_type;

   typedef enum logic [1:0] {
      SPMS_IDLE = 2'b00,
      SPMS_MSHIFT = 2'b01,
      SPMS_SSHIFT = 2'b10
   } spms_state_type;

   function automatic logic [3:0] spms_half(input logic [1:0] rate);
      spms_half = HALF_BASE << rate;
   endfunction

endpackage

// File: spms_port.sv
// Serial master/slave port with APB register access.
`timescale 1ns/100ps
module spms_port
   import spms_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [ADDR_W-1:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic irq,
   input wire logic sclk_i,
   output logic sclk_o,
   output logic sclk_oe,
   input wire logic mosi_i,
   output logic mosi_o,
   output logic mosi_oe,
   input wire logic miso_i,
   output logic miso_o,
   output logic miso_oe,
   input wire logic select_n_i
);

   // ------------------------------------------------------------
   // Pin synchronisers
   // ------------------------------------------------------------
   logic [2:0] sclk_s;
   logic [2:0] mosi_s;
   logic [2:0] miso_s;
   logic [2:0] ss_s;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_s <= 3'h0;
         mosi_s <= 3'h0;
         miso_s <= 3'h0;
         ss_s <= 3'h7;
      end else begin
         sclk_s <= {sclk_s[1:0], sclk_i};
         mosi_s <= {mosi_s[1:0], mosi_i};
         miso_s <= {miso_s[1:0], miso_i};
         ss_s <= {ss_s[1:0], select_n_i};
      end
   end
   // A change counts only once stages two and three agree.
   logic sclk_q;
   logic mosi_q;
   logic miso_q;
   logic ss_q;
   logic sclk_prev;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         sclk_q <= 1'b0;
         mosi_q <= 1'b0;
         miso_q <= 1'b0;
         ss_q <= 1'b1;
         sclk_prev <= 1'b0;
      end else begin
         if (sclk_s[1] == sclk_s[2]) sclk_q <= sclk_s[2];
         if (mosi_s[1] == mosi_s[2]) mosi_q <= mosi_s[2];
         if (miso_s[1] == miso_s[2]) miso_q <= miso_s[2];
         if (ss_s[1] == ss_s[2]) ss_q <= ss_s[2];
         sclk_prev <= sclk_q;
      end
   end

   // ------------------------------------------------------------
   // Register decode
   // ------------------------------------------------------------
   spms_ctrl_type ctrl;
   logic tcf;
   logic wcf;
   logic [7:0] rx_buf;
   spms_state_type state;
   wire logic [7:0] reg_idx = paddr[ADDR_W-3:2];
   wire logic aligned = (paddr[1:0] == ADDR_LSB_ZERO) && (paddr[ADDR_W-1:10] == 2'h0);
   wire logic hit_stat = aligned && (reg_idx == IDX_STATUS);
   wire logic hit_ctrl = aligned && (reg_idx == IDX_CONTROL);
   wire logic hit_data = aligned && (reg_idx == IDX_DATA);
   wire logic acc = psel && penable;
   wire logic wr_stat = acc && pwrite && hit_stat;
   wire logic wr_ctrl = acc && pwrite && hit_ctrl;
   wire logic wr_data = acc && pwrite && hit_data;
   assign pready = 1'b1;
   assign pslverr = acc && !(hit_stat || hit_ctrl || hit_data);
   wire logic [7:0] stat_view = {tcf, wcf, 6'h00};
   wire logic [7:0] rd_sel = hit_stat ? stat_view :
                             hit_ctrl ? ctrl :
                             hit_data ? rx_buf : 8'h00;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) prdata <= 32'h0;
      else if (psel && !penable && !pwrite) prdata <= {24'h0, rd_sel};
   end

   // ------------------------------------------------------------
   // Role selection
   // ------------------------------------------------------------
   wire logic busy = (state != SPMS_IDLE);
   wire logic is_master = ctrl.en && ctrl.mst && (ctrl.sig || ss_q);
   wire logic slave_sel = ctrl.sig ? 1'b1 : !ss_q;
   wire logic demote = ctrl.en && !ctrl.sig && ctrl.mst && !ss_q;
   // Phase 0 slave with select low: a data write collides.
   wire logic slv_col = ctrl.en && !is_master && !ctrl.pha && !ss_q;
   wire logic collide = wr_data && (busy || slv_col);
   wire logic start_m = wr_data && is_master && !busy;

   // ------------------------------------------------------------
   // Serial engine
   // ------------------------------------------------------------
   logic [7:0] shreg;
   logic [3:0] div_cnt;
   logic [4:0] edge_cnt;
   logic sclk_int;
   logic mosi_r;
   logic smp_bit;
   logic done;
   wire logic out_bit = ctrl.ord ? shreg[0] : shreg[7];
   // Shift in the sampled bit at the end opposite the outgoing one.
   function automatic logic [7:0] shift_in(input logic [7:0] v, input logic ord, input logic b);
      shift_in = ord ? {b, v[7:1]} : {v[6:0], b};
   endfunction
   wire logic tick = (div_cnt == spms_half(ctrl.rate) - 4'h1);
   // Slave edges are edges of the synchronised clock, decoded by polarity.
   wire logic s_rise = sclk_q && !sclk_prev;
   wire logic s_fall = !sclk_q && sclk_prev;
   wire logic s_lead = ctrl.pol ? s_fall : s_rise;
   wire logic s_trail = ctrl.pol ? s_rise : s_fall;
   wire logic slv_on = ctrl.en && !is_master && slave_sel;
   wire logic m_lead = tick && !edge_cnt[0];
   wire logic m_trail = tick && edge_cnt[0];
   wire logic m_samp = ctrl.pha ? m_trail : m_lead;
   wire logic m_drive = ctrl.pha ? m_lead : (m_trail && edge_cnt != EDGES_PER_BYTE - 5'h1);
   wire logic s_samp = ctrl.pha ? s_trail : s_lead;
   wire logic s_drive = ctrl.pha ? s_lead : s_trail;
   wire logic last_edge = m_trail && (edge_cnt == EDGES_PER_BYTE - 5'h1);
   logic [3:0] s_bits;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= SPMS_IDLE;
         shreg <= DATA_RESET;
         div_cnt <= 4'h0;
         edge_cnt <= 5'h0;
         sclk_int <= 1'b0;
         mosi_r <= 1'b0;
         smp_bit <= 1'b0;
         s_bits <= 4'h0;
         done <= 1'b0;
      end else begin
         done <= 1'b0;
         case (state)
            SPMS_IDLE: begin
               sclk_int <= ctrl.pol;
               div_cnt <= 4'h0;
               edge_cnt <= 5'h0;
               s_bits <= 4'h0;
               if (start_m) begin
                  shreg <= pwdata[7:0];
                  mosi_r <= ctrl.ord ? pwdata[0] : pwdata[7];
                  state <= SPMS_MSHIFT;
               end else if (wr_data && !collide) begin
                  shreg <= pwdata[7:0];
                  mosi_r <= ctrl.ord ? pwdata[0] : pwdata[7];
               end else if (slv_on && (s_samp || (ctrl.pha && s_drive))) begin
                  state <= SPMS_SSHIFT;
                  if (s_samp) begin
                     smp_bit <= mosi_q;
                     shreg <= shift_in(shreg, ctrl.ord, mosi_q);
                     s_bits <= 4'h1;
                  end
               end
            end
            SPMS_MSHIFT: begin
               if (!is_master) begin
                  state <= SPMS_IDLE;
                  sclk_int <= ctrl.pol;
               end else begin
                  div_cnt <= tick ? 4'h0 : div_cnt + 4'h1;
                  if (tick) begin
                     sclk_int <= !sclk_int;
                     edge_cnt <= edge_cnt + 5'h1;
                  end
                  if (m_samp) smp_bit <= miso_q;
                  if (m_drive && ctrl.pha) mosi_r <= out_bit;
                  if (m_trail && !ctrl.pha) begin
                     shreg <= shift_in(shreg, ctrl.ord, smp_bit);
                     mosi_r <= ctrl.ord ? shreg[1] : shreg[6];
                  end
                  if (m_trail && ctrl.pha) shreg <= shift_in(shreg, ctrl.ord, miso_q);
                  if (last_edge) begin
                     state <= SPMS_IDLE;
                     done <= 1'b1;
                  end
               end
            end
            SPMS_SSHIFT: begin
               if (!slv_on) begin
                  state <= SPMS_IDLE;
               end else begin
                  if (s_drive && ctrl.pha) mosi_r <= out_bit;
                  if (s_samp) begin
                     shreg <= shift_in(shreg, ctrl.ord, mosi_q);
                     s_bits <= s_bits + 4'h1;
                     if (s_bits == BITS_PER_BYTE - 4'h1) begin
                        state <= SPMS_IDLE;
                        done <= 1'b1;
                     end
                  end
                  if (s_drive && !ctrl.pha) mosi_r <= out_bit;
               end
            end
            default: state <= SPMS_IDLE;
         endcase
      end
   end

   // ------------------------------------------------------------
   // Control, flags and read buffer
   // ------------------------------------------------------------
   logic was_master;
   wire logic mode_chg = !ctrl.sig && ctrl.en && (was_master != is_master);
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl <= CONTROL_RESET;
         tcf <= 1'b0;
         wcf <= 1'b0;
         rx_buf <= DATA_RESET;
         was_master <= 1'b0;
      end else begin
         was_master <= is_master;
         if (wr_ctrl) ctrl <= pwdata[7:0];
         else if (demote) ctrl.mst <= 1'b0;
         // Set wins over a simultaneous clear.
         if (done || mode_chg || demote) tcf <= 1'b1;
         else if (wr_stat && pwdata[BIT_TCF]) tcf <= 1'b0;
         if (collide) wcf <= 1'b1;
         else if (wr_stat && pwdata[BIT_WCF]) wcf <= 1'b0;
         // The shift register already holds all eight bits when done is seen.
         if (done) rx_buf <= shreg;
      end
   end
   assign irq = tcf;

   // ------------------------------------------------------------
   // Pin drivers
   // ------------------------------------------------------------
   // Slave data out follows the register so phase-0 first bit appears on select.
   wire logic slv_bit = (state == SPMS_SSHIFT && ctrl.pha) ? mosi_r : out_bit;
   always_comb begin
      sclk_o = sclk_int;
      sclk_oe = is_master;
      mosi_o = mosi_r;
      mosi_oe = is_master;
      miso_o = slv_bit;
      miso_oe = slv_on;
   end

   // ------------------------------------------------------------
   // Checks
   // ------------------------------------------------------------
   property p_flag_set;
      @(posedge pclk) disable iff (!presetn) done |=> tcf;
   endproperty
   a_flag_set: assert property (p_flag_set) else $error("flag not set after byte");

   property p_clear_only;
      @(posedge pclk) disable iff (!presetn)
         $fell(tcf) |-> $past(wr_stat) && $past(pwdata[BIT_TCF]);
   endproperty
   a_clear_only: assert property (p_clear_only) else $error("flag fell without write");

   property p_collide;
      @(posedge pclk) disable iff (!presetn) (wr_data && busy) |=> wcf;
   endproperty
   a_collide: assert property (p_collide) else $error("collision not flagged");

   property p_disabled;
      @(posedge pclk) disable iff (!presetn)
         !ctrl.en |-> !sclk_oe && !mosi_oe && !miso_oe;
   endproperty
   a_disabled: assert property (p_disabled) else $error("pins driven while off");

   property p_demote;
      @(posedge pclk) disable iff (!presetn) (demote && !wr_ctrl) |=> !ctrl.mst && tcf;
   endproperty
   a_demote: assert property (p_demote) else $error("master not demoted");

   property p_float;
      @(posedge pclk) disable iff (!presetn)
         (ctrl.en && !ctrl.sig && !ctrl.mst && ss_q) |-> !miso_oe;
   endproperty
   a_float: assert property (p_float) else $error("unselected slave drives");

   sequence s_start;
      start_m;
   endsequence
   property p_start;
      @(posedge pclk) disable iff (!presetn) s_start |=> state == SPMS_MSHIFT;
   endproperty
   a_start: assert property (p_start) else $error("transfer did not start");

   property p_idle_clk;
      @(posedge pclk) disable iff (!presetn)
         (state == SPMS_IDLE && $past(state) == SPMS_IDLE && is_master) |->
            sclk_o == $past(ctrl.pol);
   endproperty
   a_idle_clk: assert property (p_idle_clk) else $error("clock not idle");

   property p_rx_copy;
      @(posedge pclk) disable iff (!presetn) done |=> rx_buf == $past(shreg);
   endproperty
   a_rx_copy: assert property (p_rx_copy) else $error("buffer not updated");

endmodule // spms_port

// File: spms_slave_model.sv
// Behavioural far-side serial slave that swaps one byte with the port.
`timescale 1ns/100ps
module spms_slave_model (
   input wire logic sclk,
   input wire logic mosi,
   input wire logic pol,
   input wire logic pha,
   input wire logic ord,
   input wire logic load,
   input wire logic [7:0] tx,
   output logic miso,
   output logic [7:0] rx
);
   int i = 0;
   initial miso = 1'b0;
   // Past the last bit the line shows the inverse of its last level, so stale data never passes.
   function automatic logic pick(input int k);
      pick = (k > 7) ? ~miso : (ord ? tx[k] : tx[7-k]);
   endfunction
   // ------------------------------------------------------------
   // Framing
   // ------------------------------------------------------------
   always @(load) begin
      i = 0;
      rx = 8'h00;
      miso = pha ? ~miso : pick(0);
   end
   // ------------------------------------------------------------
   // Shifting
   // ------------------------------------------------------------
   always @(sclk) begin
      if ((sclk != pol) == !pha) begin
         rx = ord ? {mosi, rx[7:1]} : {rx[6:0], mosi};
      end else if (pha) begin
         miso = pick(i);
         i = i + 1;
      end else begin
         i = i + 1;
         miso = pick(i);
      end
   end
endmodule // spms_slave_model
